/* File: core/offset_regs_defs.svh */
// offset, weight, status and identifier register constants
`ifndef OFFSET_REGS_DEFS_SVH
`define OFFSET_REGS_DEFS_SVH
`define ADDR_W            9
`define DATA_W            8
`define ADDR_CH5_OFFSET   9'h0a3
`define ADDR_CH6_OFFSET   9'h0a4
`define ADDR_CH7_OFFSET   9'h0a5
`define ADDR_WEIGHT       9'h0a7
`define ADDR_CAL_STAT     9'h0c0
`define ADDR_PLL_STAT     9'h0d1
`define ADDR_ID_LOW       9'h15c
`define ADDR_ID_HIGH      9'h15d
`define ADDR_IRQ_STAT     9'h1e0
`define ADDR_IRQ_MASK     9'h1e1
`define RST_OFFSET        8'h00
`define RST_WEIGHT        8'h47
`define RST_MASK          8'h00
`define WEIGHT_LSB        3
`define WEIGHT_MSB        4
`define CAL_DONE_BIT      7
`define PLL_CAL_BIT       5
`define PLL_LOW_BIT       2
`define PLL_HIGH_BIT      1
`define PLL_FACTORY_MASK  8'hd9
`define CAL_FACTORY_MASK  8'h7f
`define IRQ_CAL_BIT       0
`define IRQ_PLL_CAL_BIT   1
`define IRQ_PLL_LOW_BIT   2
`define IRQ_PLL_HIGH_BIT  3
`define CAL_EXP           27
`define OFFSET_OUT_W      12
`endif

/* File: core/offset_regs_pkg.sv */
// types for the offset weight and status register group
package offset_regs_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    W_QUARTER = 4'h1,
    W_HALF    = 4'h2,
    W_ONE     = 4'h4,
    W_TWO     = 4'h8
  } weight_e;
endpackage : offset_regs_pkg

/* File: core/offset_scale.sv */
// scales one signed offset code by the shared weight, in quarter lsb units
`include "offset_regs_defs.svh"
module offset_scale
  import offset_regs_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  // code and weight
  input  wire offset_regs_pkg::byte_t      code_in,
  input  wire logic [1:0]                  weight_in,
  // scaled result
  output logic signed [`OFFSET_OUT_W-1:0]  scaled_out
);
  logic signed [`OFFSET_OUT_W-1:0] wide_code;

  assign wide_code = `OFFSET_OUT_W'(signed'(code_in));

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scaled_out <= '0;
    end else begin
      scaled_out <= wide_code <<< weight_in;
    end
  end
endmodule : offset_scale

/* File: core/offset_weight_status_regs.sv */
// offset, weight, calibration status, pll status and identifier registers
`include "offset_regs_defs.svh"
module offset_weight_status_regs
  import offset_regs_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = (1 << `CAL_EXP),
  parameter logic [15:0] DEVICE_ID  = 16'h5aa5 // arbitrary value
) (
  // clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  // register port
  input  wire logic [`ADDR_W-1:0]          addr_in,
  input  wire offset_regs_pkg::byte_t      wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output offset_regs_pkg::byte_t           rdata_out,
  // status sources
  input  wire logic                        pll_cal_done_in,
  input  wire logic                        pll_drift_low_in,
  input  wire logic                        pll_drift_high_in,
  input  wire logic [4:0]                  pll_factory_in,
  // offset datapath
  output logic signed [`OFFSET_OUT_W-1:0]  ch5_offset_out,
  output logic signed [`OFFSET_OUT_W-1:0]  ch6_offset_out,
  output logic signed [`OFFSET_OUT_W-1:0]  ch7_offset_out,
  output logic [1:0]                       offset_step_scale_out,
  output offset_regs_pkg::weight_e         weight_mode_out,
  output logic                             cal_done_out,
  // interrupt
  output logic                             irq_out
);
  // elaboration check: the timer counts at most 2^27 cycles
  if (CAL_CYCLES < 2 || CAL_CYCLES > (1 << `CAL_EXP)) begin : g_bad_cal
    $error("CAL_CYCLES out of range");
  end

  byte_t channel5_offset_code_reg;
  byte_t channel6_offset_code_reg;
  byte_t channel7_offset_code_reg;
  byte_t weight_ctrl_reg;
  byte_t irq_stat_reg;
  byte_t irq_mask_reg;
  byte_t irq_set;
  byte_t pll_stat;
  byte_t cal_stat;
  byte_t rdata_next;
  logic  cal_done_reg;
  logic [`CAL_EXP:0] cal_cnt_reg;
  logic  pll_cal_q;
  logic  pll_low_q;
  logic  pll_high_q;
  logic [1:0] weight_field;
  byte_t scale_code [3];

  function automatic logic hit(input logic [`ADDR_W-1:0] a,
                               input logic [`ADDR_W-1:0] target);
    hit = (a == target);
  endfunction : hit

  function automatic weight_e decode_weight(input logic [1:0] f);
    unique case (f)
      2'b00: decode_weight = W_QUARTER;
      2'b01: decode_weight = W_HALF;
      2'b10: decode_weight = W_ONE;
      2'b11: decode_weight = W_TWO;
    endcase
  endfunction : decode_weight

  // offset code registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      channel5_offset_code_reg <= `RST_OFFSET;
      channel6_offset_code_reg <= `RST_OFFSET;
      channel7_offset_code_reg <= `RST_OFFSET;
    end else if (wr_in) begin
      if (hit(addr_in, `ADDR_CH5_OFFSET)) begin
        channel5_offset_code_reg <= wdata_in;
      end
      if (hit(addr_in, `ADDR_CH6_OFFSET)) begin
        channel6_offset_code_reg <= wdata_in;
      end
      if (hit(addr_in, `ADDR_CH7_OFFSET)) begin
        channel7_offset_code_reg <= wdata_in;
      end
    end
  end

  // weight control, whole byte stored as written
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      weight_ctrl_reg <= `RST_WEIGHT;
    end else if (wr_in && hit(addr_in, `ADDR_WEIGHT)) begin
      weight_ctrl_reg <= wdata_in;
    end
  end

  assign weight_field = weight_ctrl_reg[`WEIGHT_MSB:`WEIGHT_LSB];
  assign scale_code[0] = channel5_offset_code_reg;
  assign scale_code[1] = channel6_offset_code_reg;
  assign scale_code[2] = channel7_offset_code_reg;

  // one shared weight field feeds every channel scaler
  logic signed [`OFFSET_OUT_W-1:0] scaled [3];
  for (genvar g = 0; g < 3; g++) begin : g_scale
    offset_scale u_scale (
      .sys_clk_in (sys_clk_in),
      .rst_b_in   (rst_b_in),
      .code_in    (scale_code[g]),
      .weight_in  (weight_field),
      .scaled_out (scaled[g])
    );
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ch5_offset_out        <= '0;
      ch6_offset_out        <= '0;
      ch7_offset_out        <= '0;
      offset_step_scale_out <= 2'b00;
      weight_mode_out       <= W_QUARTER;
    end else begin
      ch5_offset_out        <= scaled[0];
      ch6_offset_out        <= scaled[1];
      ch7_offset_out        <= scaled[2];
      offset_step_scale_out <= weight_field;
      weight_mode_out       <= decode_weight(weight_field);
    end
  end

  // power-up calibration timer, flag sticks until reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_cnt_reg  <= '0;
      cal_done_reg <= 1'b0;
    end else if (!cal_done_reg) begin
      cal_cnt_reg <= cal_cnt_reg + 1'b1;
      if (cal_cnt_reg == (`CAL_EXP+1)'(CAL_CYCLES - 1)) begin
        cal_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cal_done_out <= 1'b0;
    end else begin
      cal_done_out <= cal_done_reg;
    end
  end

  // pll status sampling
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pll_cal_q  <= 1'b0;
      pll_low_q  <= 1'b0;
      pll_high_q <= 1'b0;
    end else begin
      pll_cal_q  <= pll_cal_done_in;
      pll_low_q  <= pll_drift_low_in;
      pll_high_q <= pll_drift_high_in;
    end
  end

  always_comb begin
    cal_stat = '0;
    cal_stat[`CAL_DONE_BIT] = cal_done_reg;
    pll_stat = {pll_factory_in[4:3], pll_cal_q, pll_factory_in[2:1],
                pll_low_q, pll_high_q, pll_factory_in[0]};
  end

  // interrupt status, set wins over write-one clear
  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_CAL_BIT]      = cal_done_reg & ~cal_done_out;
    irq_set[`IRQ_PLL_CAL_BIT]  = pll_cal_done_in & ~pll_cal_q;
    irq_set[`IRQ_PLL_LOW_BIT]  = pll_drift_low_in & ~pll_low_q;
    irq_set[`IRQ_PLL_HIGH_BIT] = pll_drift_high_in & ~pll_high_q;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_stat_reg <= '0;
    end else if (wr_in && hit(addr_in, `ADDR_IRQ_STAT)) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata_in) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_mask_reg <= `RST_MASK;
    end else if (wr_in && hit(addr_in, `ADDR_IRQ_MASK)) begin
      irq_mask_reg <= wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read mux, reads have no side effect
  always_comb begin
    unique case (addr_in)
      `ADDR_CH5_OFFSET: rdata_next = channel5_offset_code_reg;
      `ADDR_CH6_OFFSET: rdata_next = channel6_offset_code_reg;
      `ADDR_CH7_OFFSET: rdata_next = channel7_offset_code_reg;
      `ADDR_WEIGHT:     rdata_next = weight_ctrl_reg;
      `ADDR_CAL_STAT:   rdata_next = cal_stat;
      `ADDR_PLL_STAT:   rdata_next = pll_stat;
      `ADDR_ID_LOW:     rdata_next = DEVICE_ID[7:0];
      `ADDR_ID_HIGH:    rdata_next = DEVICE_ID[15:8];
      `ADDR_IRQ_STAT:   rdata_next = irq_stat_reg;
      `ADDR_IRQ_MASK:   rdata_next = irq_mask_reg;
      default:          rdata_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= '0;
    end
  end

  // checks
  logic signed [`OFFSET_OUT_W-1:0] wide5;
  assign wide5 = `OFFSET_OUT_W'(signed'(channel5_offset_code_reg));

  chk_offset_write_lands: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wr_in && addr_in == `ADDR_CH5_OFFSET |=> channel5_offset_code_reg == $past(wdata_in))
    else $error("channel 5 offset write lost");
  chk_ch6_write_lands: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wr_in && addr_in == `ADDR_CH6_OFFSET |=> channel6_offset_code_reg == $past(wdata_in))
    else $error("channel 6 offset write lost");
  chk_ch7_read_back: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    rd_in && addr_in == `ADDR_CH7_OFFSET && !$past(wr_in)
    |=> rdata_out == channel7_offset_code_reg)
    else $error("channel 7 offset readback wrong");
  chk_scale_applied: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $stable(weight_field) && $stable(channel5_offset_code_reg) ##1
    $stable(weight_field) && $stable(channel5_offset_code_reg)
    |=> ch5_offset_out == ($past(wide5, 2) <<< $past(weight_field, 2)))
    else $error("channel 5 scaled offset wrong");
  chk_weight_decode: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    weight_field == 2'b11 |=> weight_mode_out == W_TWO)
    else $error("weight decode wrong");
  chk_cal_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    cal_done_reg |=> cal_done_reg [*2])
    else $error("calibration flag dropped");
  chk_cal_status_bits: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    rd_in && addr_in == `ADDR_CAL_STAT
    |=> rdata_out == {$past(cal_done_reg), 7'h00})
    else $error("calibration status read wrong");
  chk_cal_bound: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !cal_done_reg |-> cal_cnt_reg < (`CAL_EXP+1)'(CAL_CYCLES))
    else $error("calibration overran");
  chk_pll_low_read: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    rd_in && addr_in == `ADDR_PLL_STAT
    |=> rdata_out[`PLL_LOW_BIT] == $past(pll_low_q)
        && rdata_out[`PLL_HIGH_BIT] == $past(pll_high_q))
    else $error("pll drift bits wrong");
  chk_id_read: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    rd_in && addr_in == `ADDR_ID_HIGH |=> rdata_out == DEVICE_ID[15:8])
    else $error("identifier high byte wrong");

  cov_weight_two: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    wr_in && addr_in == `ADDR_WEIGHT && wdata_in[`WEIGHT_MSB:`WEIGHT_LSB] == 2'b11);
  cov_cal_done: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $rose(cal_done_reg));
  cov_irq: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in) $rose(irq_out));
  cov_neg_offset: cover property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ch6_offset_out < 0);
endmodule : offset_weight_status_regs

/* File: testbench/offset_weight_status_regs_test.sv */
// self-checking bench for the offset weight and status register group
`include "offset_regs_defs.svh"
module offset_weight_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import offset_regs_pkg::*;

  localparam int unsigned CAL_N = 64;

  logic                           sys_clk_in;
  logic                           rst_b_in;
  logic [`ADDR_W-1:0]             addr_in;
  byte_t                          wdata_in;
  logic                           wr_in;
  logic                           rd_in;
  byte_t                          rdata_out;
  logic                           pll_cal_done_in;
  logic                           pll_drift_low_in;
  logic                           pll_drift_high_in;
  logic [4:0]                     pll_factory_in;
  logic signed [`OFFSET_OUT_W-1:0] ch5_offset_out;
  logic signed [`OFFSET_OUT_W-1:0] ch6_offset_out;
  logic signed [`OFFSET_OUT_W-1:0] ch7_offset_out;
  logic [1:0]                     offset_step_scale_out;
  weight_e                        weight_mode_out;
  logic                           cal_done_out;
  logic                           irq_out;
  int                             n_mismatch;
  int                             compares;
  byte_t                          codes [3];

  offset_weight_status_regs #(.CAL_CYCLES(CAL_N)) dut (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pll_cal_done_in(pll_cal_done_in),
    .pll_drift_low_in(pll_drift_low_in), .pll_drift_high_in(pll_drift_high_in),
    .pll_factory_in(pll_factory_in), .ch5_offset_out(ch5_offset_out),
    .ch6_offset_out(ch6_offset_out), .ch7_offset_out(ch7_offset_out),
    .offset_step_scale_out(offset_step_scale_out), .weight_mode_out(weight_mode_out),
    .cal_done_out(cal_done_out), .irq_out(irq_out));

  always #20 sys_clk_in = ~sys_clk_in;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [`ADDR_W-1:0] a, input byte_t d);
    @(posedge sys_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [`ADDR_W-1:0] a, output byte_t d);
    @(posedge sys_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in   <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata_out;
  endtask : rd

  task automatic rd_chk(input logic [`ADDR_W-1:0] a, input byte_t e);
    byte_t d;
    rd(a, d);
    check(16'(d), 16'(e));
  endtask : rd_chk

  function automatic byte_t pll_exp(input logic [4:0] f, input logic c, input logic l,
                                    input logic h);
    return {f[4:3], c, f[2:1], l, h, f[0]};
  endfunction : pll_exp

  function automatic logic [15:0] scaled(input byte_t c, input int w);
    logic signed [`OFFSET_OUT_W-1:0] v;
    v = `OFFSET_OUT_W'(signed'(c));
    return 16'(`OFFSET_OUT_W'(v <<< w));
  endfunction : scaled

  task automatic print_verdict;
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #(40 * 5000);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    sys_clk_in = 1'b0; rst_b_in = 1'b0; addr_in = '0; wdata_in = '0; wr_in = 1'b0;
    rd_in = 1'b0; pll_cal_done_in = 1'b0; pll_drift_low_in = 1'b0;
    pll_drift_high_in = 1'b0; pll_factory_in = 5'h15;
    n_mismatch = 0; compares = 0;
    codes = '{8'h80, 8'h7f, 8'hff};
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // reset values
    rd_chk(`ADDR_CAL_STAT, 8'h00);
    check(16'(cal_done_out), 16'h0);
    rd_chk(`ADDR_CH5_OFFSET, 8'h00);
    rd_chk(`ADDR_CH6_OFFSET, 8'h00);
    rd_chk(`ADDR_CH7_OFFSET, 8'h00);
    rd_chk(`ADDR_WEIGHT, 8'h47);
    check(16'(weight_mode_out), 16'h1);
    check(16'(ch5_offset_out), 16'h0);
    rd_chk(`ADDR_IRQ_MASK, 8'h00);
    rd_chk(9'h1ff, 8'h00);
    // channel codes written and read back
    wr(`ADDR_CH5_OFFSET, codes[0]);
    wr(`ADDR_CH6_OFFSET, codes[1]);
    wr(`ADDR_CH7_OFFSET, codes[2]);
    rd_chk(`ADDR_CH5_OFFSET, codes[0]);
    rd_chk(`ADDR_CH6_OFFSET, codes[1]);
    rd_chk(`ADDR_CH7_OFFSET, codes[2]);
    // every weight setting scales all three channels, factory bits kept
    for (int w = 3; w >= 0; w--) begin
      wr(`ADDR_WEIGHT, 8'h47 | byte_t'(w << 3));
      repeat (4) @(posedge sys_clk_in);
      rd_chk(`ADDR_WEIGHT, 8'h47 | byte_t'(w << 3));
      check(16'(offset_step_scale_out), 16'(w));
      check(16'(weight_mode_out), 16'(4'h1 << w));
      check(16'(ch5_offset_out), scaled(codes[0], w));
      check(16'(ch6_offset_out), scaled(codes[1], w));
      check(16'(ch7_offset_out), scaled(codes[2], w));
    end
    // read-only places ignore writes
    wr(`ADDR_CAL_STAT, 8'hff);
    wr(`ADDR_PLL_STAT, 8'h00);
    wr(`ADDR_ID_LOW, 8'h00);
    wr(`ADDR_ID_HIGH, 8'h00);
    rd_chk(`ADDR_ID_LOW, 8'ha5);
    rd_chk(`ADDR_ID_HIGH, 8'h5a);
    rd_chk(`ADDR_PLL_STAT, pll_exp(5'h15, 1'b0, 1'b0, 1'b0));
    // calibration completion
    for (int i = 0; i < 200 && cal_done_out !== 1'b1; i++) @(negedge sys_clk_in);
    check(16'(cal_done_out), 16'h1);
    rd_chk(`ADDR_CAL_STAT, 8'h80);
    rd_chk(`ADDR_CAL_STAT, 8'h80);
    // pll flags, each alone then together
    @(posedge sys_clk_in);
    pll_factory_in <= 5'h0a;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_in);
      pll_cal_done_in   <= (k == 0 || k == 3);
      pll_drift_low_in  <= (k == 1 || k == 3);
      pll_drift_high_in <= (k == 2 || k == 3);
      repeat (2) @(posedge sys_clk_in);
      rd_chk(`ADDR_PLL_STAT, pll_exp(5'h0a, k == 0 || k == 3, k == 1 || k == 3,
                                     k == 2 || k == 3));
    end
    // interrupt status, mask and clear
    rd_chk(`ADDR_IRQ_STAT, 8'h0f);
    check(16'(irq_out), 16'h0);
    wr(`ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(negedge sys_clk_in);
    check(16'(irq_out), 16'h1);
    wr(`ADDR_IRQ_STAT, 8'h02);
    repeat (2) @(negedge sys_clk_in);
    check(16'(irq_out), 16'h0);
    rd_chk(`ADDR_IRQ_STAT, 8'h0d);
    rd_chk(`ADDR_CAL_STAT, 8'h80);
    print_verdict();
  end
endmodule : offset_weight_status_regs_test
